/* hw/pls_top.sv */
// Purpose: link start-up sequencing with APB registers
// Assumes: line status inputs synchronous to pclk
// Notes: one wait-state APB slave, PSLVERR on unmapped address
`timescale 1ns/10ps
`include "pls_consts.svh"
module pls_top (
    input wire logic pclk, // Core clock 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic lp_capability_exchange_ok, // Partner finished exchange
    input wire logic lp_no_capability_exchange, // Partner silent on exchange
    input wire logic [1:0] pdet_speed, // Parallel detected speed
    input wire logic [2:0] lp_abil, // Partner abilities 10/100/1000
    input wire logic lp_pulse_ok, // Valid link pulses seen
    input wire logic [3:0] pol_sense, // Pair polarity sense
    input wire logic train_ok, // Training completed
    input wire logic train_fail, // Training failed
    input wire logic cable_bad, // Cabling unfit for gigabit
    input wire logic sig_bad, // Signal integrity unfit
    input wire logic link_lost, // Link dropped on line
    output logic [1:0] xover_mode_o, // Crossover mode
    output logic [3:0] pol_inv_o, // Polarity inversion
    output logic capability_exchange_active, // Capability exchange running
    output logic xpage_active, // Extra page exchange running
    output logic [2:0] adv_o, // Abilities advertised
    output logic link_up_o, // Link established
    output logic [1:0] speed_o // Link speed
);
    logic [4:0] ctrl_ff, nxt_ctrl;
    logic [2:0] adv_ff, nxt_adv;
    logic [15:0] err_ff, nxt_err;
    logic [31:0] rd_ff, nxt_rd;
    logic rdy_ff, nxt_rdy;
    logic slv_ff, nxt_slv;
    pls_pkg::pls_state_t st_ff, nxt_st;
    pls_pkg::pls_speed_t spd_ff, nxt_spd;
    logic capability_exchange_ff, nxt_capability_exchange;
    logic xpg_ff, nxt_xpg;
    logic up_ff, nxt_up;
    logic xdone;
    logic [1:0] xmode;
    logic [3:0] pinv;
    logic fall;
    logic g_fail;
    logic g_up;
    logic fb_en;

    // Decode a byte address to a known register
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `PLS_CTRL_OFF) || (a == `PLS_ADV_OFF) ||
            (a == `PLS_STAT_OFF) || (a == `PLS_ERRCNT_OFF);
    endfunction

    // Pick the highest common ability
    function automatic pls_pkg::pls_speed_t best(input logic [2:0] ab);
        if (ab[2]) begin
            best = pls_pkg::PLS_SPD_1000;
        end else if (ab[1]) begin
            best = pls_pkg::PLS_SPD_100;
        end else begin
            best = pls_pkg::PLS_SPD_10;
        end
    endfunction

    wire acc = psel && penable && !rdy_ff;
    wire wr = acc && pwrite && addr_hit(paddr);

    // Gigabit-only advertisement cannot fall back
    assign fb_en = (adv_ff[1:0] != 2'h0);
    assign g_fail = (st_ff == pls_pkg::PLS_TRAIN) && train_fail;
    assign g_up = (st_ff == pls_pkg::PLS_TRAIN) && train_ok;

    // Crossover and polarity helper
    pls_xover u_xover (
        .pclk(pclk),
        .presetn(presetn),
        .search(st_ff == pls_pkg::PLS_XOVER),
        .xover_en(ctrl_ff[`PLS_CTRL_XOVER_EN]),
        .pol_en(ctrl_ff[`PLS_CTRL_POL_EN]),
        .link_up(up_ff),
        .speed(spd_ff),
        .lp_pulse_ok(lp_pulse_ok),
        .pol_sense(pol_sense),
        .xover_mode(xmode),
        .pol_inv(pinv),
        .xover_done(xdone)
    );

    // Fallback decision helper
    pls_fallback u_fb (
        .pclk(pclk),
        .presetn(presetn),
        .enable(fb_en),
        .g_fail(g_fail),
        .g_up(g_up),
        .cable_bad(cable_bad && st_ff == pls_pkg::PLS_TRAIN),
        .sig_bad(sig_bad && st_ff == pls_pkg::PLS_TRAIN),
        .fall_pulse(fall)
    );

    // Register file and APB answer
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_adv = adv_ff;
        nxt_err = err_ff;
        nxt_rd = rd_ff;
        nxt_rdy = acc;
        nxt_slv = acc && !addr_hit(paddr);
        nxt_ctrl[`PLS_CTRL_RESTART] = 1'b0;
        if (wr && paddr == `PLS_CTRL_OFF) begin
            nxt_ctrl = pwdata[4:0];
        end
        if (wr && paddr == `PLS_ADV_OFF) begin
            nxt_adv = pwdata[2:0];
        end
        // Fallback wins over a software write to advertisement
        if (fall) begin
            nxt_adv[2] = 1'b0;
            if (err_ff != 16'hffff) begin
                nxt_err = err_ff + 16'h1;
            end
        end
        if (acc && !pwrite) begin
            case (paddr)
                `PLS_CTRL_OFF: nxt_rd = {27'h0, ctrl_ff};
                `PLS_ADV_OFF: nxt_rd = {29'h0, adv_ff};
                `PLS_STAT_OFF: nxt_rd = {22'h0, pinv, xmode,
                    spd_ff, up_ff, st_ff[0]};
                `PLS_ERRCNT_OFF: nxt_rd = {16'h0, err_ff};
                default: nxt_rd = 32'h0;
            endcase
        end
    end

    // Start-up sequencer next state
    always_comb begin
        nxt_st = st_ff;
        nxt_spd = spd_ff;
        nxt_capability_exchange = 1'b0;
        nxt_xpg = 1'b0;
        nxt_up = up_ff;
        unique case (st_ff)
            pls_pkg::PLS_IDLE: begin
                nxt_up = 1'b0;
                nxt_st = pls_pkg::PLS_XOVER;
            end
            pls_pkg::PLS_XOVER: begin
                if (xdone) begin
                    if (ctrl_ff[`PLS_CTRL_CAPABILITY_EXCHANGE_EN]) begin
                        nxt_st = pls_pkg::PLS_CAPABILITY_EXCHANGE;
                    end else begin
                        nxt_st = pls_pkg::PLS_PDET;
                    end
                end
            end
            pls_pkg::PLS_CAPABILITY_EXCHANGE: begin
                nxt_capability_exchange = 1'b1;
                // Extra pages carry gigabit ability unaided
                nxt_xpg = ctrl_ff[`PLS_CTRL_XPAGE_EN] && adv_ff[2];
                if (lp_no_capability_exchange) begin
                    nxt_st = pls_pkg::PLS_PDET;
                end else if (lp_capability_exchange_ok) begin
                    nxt_spd = best(adv_ff & lp_abil);
                    if (best(adv_ff & lp_abil) == pls_pkg::PLS_SPD_1000) begin
                        nxt_st = pls_pkg::PLS_TRAIN;
                    end else begin
                        nxt_st = pls_pkg::PLS_UP;
                        nxt_up = 1'b1;
                    end
                end
            end
            pls_pkg::PLS_PDET: begin
                nxt_spd = pls_pkg::pls_speed_t'(pdet_speed);
                if (lp_pulse_ok) begin
                    nxt_st = pls_pkg::PLS_UP;
                    nxt_up = 1'b1;
                end
            end
            pls_pkg::PLS_TRAIN: begin
                if (train_ok) begin
                    nxt_st = pls_pkg::PLS_UP;
                    nxt_up = 1'b1;
                end else if (train_fail || cable_bad || sig_bad) begin
                    nxt_st = pls_pkg::PLS_IDLE;
                end
            end
            pls_pkg::PLS_UP: begin
                if (link_lost) begin
                    nxt_st = pls_pkg::PLS_IDLE;
                    nxt_up = 1'b0;
                end
            end
            default: begin
                nxt_st = pls_pkg::PLS_IDLE;
            end
        endcase
        if (ctrl_ff[`PLS_CTRL_RESTART]) begin
            nxt_st = pls_pkg::PLS_IDLE;
            nxt_up = 1'b0;
        end
        // Exchange flags drop with the state so they never overlap link up
        if (nxt_st != pls_pkg::PLS_CAPABILITY_EXCHANGE) begin
            nxt_capability_exchange = 1'b0;
            nxt_xpg = 1'b0;
        end
    end

    // Register stage for all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 5'(`PLS_CTRL_RST);
            adv_ff <= 3'(`PLS_ADV_RST);
            err_ff <= 16'h0;
            rd_ff <= 32'h0;
            rdy_ff <= 1'b0;
            slv_ff <= 1'b0;
            st_ff <= pls_pkg::PLS_IDLE;
            spd_ff <= pls_pkg::PLS_SPD_10;
            capability_exchange_ff <= 1'b0;
            xpg_ff <= 1'b0;
            up_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            adv_ff <= nxt_adv;
            err_ff <= nxt_err;
            rd_ff <= nxt_rd;
            rdy_ff <= nxt_rdy;
            slv_ff <= nxt_slv;
            st_ff <= nxt_st;
            spd_ff <= nxt_spd;
            capability_exchange_ff <= nxt_capability_exchange;
            xpg_ff <= nxt_xpg;
            up_ff <= nxt_up;
        end
    end

    assign prdata = rd_ff;
    assign pready = rdy_ff;
    assign pslverr = slv_ff;
    assign xover_mode_o = xmode;
    assign pol_inv_o = pinv;
    assign capability_exchange_active = capability_exchange_ff;
    assign xpage_active = xpg_ff;
    assign adv_o = adv_ff;
    assign link_up_o = up_ff;
    assign speed_o = spd_ff;
endmodule

/* common/pls_consts.svh */
// Purpose: constants for the link start-up control block
// Assumes: APB, 32-bit data, byte addresses
// Notes: offsets are word aligned
`ifndef PLS_CONSTS_SVH
`define PLS_CONSTS_SVH
`define PLS_CTRL_OFF 12'h000
`define PLS_ADV_OFF 12'h004
`define PLS_STAT_OFF 12'h008
`define PLS_ERRCNT_OFF 12'h00c
`define PLS_CTRL_RST 32'h0000_000f
`define PLS_ADV_RST 32'h0000_0007
`define PLS_CTRL_CAPABILITY_EXCHANGE_EN 0
`define PLS_CTRL_XOVER_EN 1
`define PLS_CTRL_POL_EN 2
`define PLS_CTRL_XPAGE_EN 3
`define PLS_CTRL_RESTART 4
`define PLS_ATTEMPT_MAX 3
`define PLS_XOVER_TIME_US 10
`define PLS_XOVER_CYC ((`PLS_XOVER_TIME_US * 1000) / 10)
`define PLS_ERR_VAL 32'hdead_beef
`endif

/* common/pls_pkg.sv */
// Purpose: types for the link start-up control block
// Assumes: one-hot state codes
// Notes: used with package scope only
package pls_pkg;
    typedef enum logic [5:0] {
        PLS_IDLE = 6'h01,
        PLS_XOVER = 6'h02,
        PLS_CAPABILITY_EXCHANGE = 6'h04,
        PLS_TRAIN = 6'h08,
        PLS_UP = 6'h10,
        PLS_PDET = 6'h20
    } pls_state_t;
    typedef enum logic [1:0] {
        PLS_SPD_10 = 2'h0,
        PLS_SPD_100 = 2'h1,
        PLS_SPD_1000 = 2'h2
    } pls_speed_t;
endpackage

/* hw/pls_xover.sv */
// Purpose: crossover mode search and receive polarity hold
// Assumes: link pulse and pair polarity qualifiers from the analog front end
// Notes: polarity is held while link is up
`timescale 1ns/10ps
`include "pls_consts.svh"
module pls_xover (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire logic search, // Crossover search active
    input wire logic xover_en, // Crossover correction enable
    input wire logic pol_en, // Polarity correction enable
    input wire logic link_up, // Link established
    input wire logic [1:0] speed, // Resolved speed
    input wire logic lp_pulse_ok, // Valid link pulses seen
    input wire logic [3:0] pol_sense, // Pair polarity sense
    output logic [1:0] xover_mode, // Crossover mode 0..3
    output logic [3:0] pol_inv, // Receive polarity inversion
    output logic xover_done // Search has locked
);
    logic [1:0] mode_ff, nxt_mode;
    logic [3:0] pol_ff, nxt_pol;
    logic [13:0] tmr_ff, nxt_tmr;
    logic done_ff, nxt_done;
    // Next values: step modes until partner pulses are seen
    always_comb begin
        nxt_mode = mode_ff;
        nxt_pol = pol_ff;
        nxt_tmr = tmr_ff;
        nxt_done = done_ff;
        if (!xover_en) begin
            nxt_mode = 2'h0;
            nxt_done = search;
        end else if (search && !done_ff) begin
            if (lp_pulse_ok) begin
                nxt_done = 1'b1;
            end else if (tmr_ff == 14'(`PLS_XOVER_CYC - 1)) begin
                nxt_tmr = 14'h0;
                // Slow speeds use only two distinct modes
                if (speed != pls_pkg::PLS_SPD_1000) begin
                    nxt_mode = {1'b0, ~mode_ff[0]};
                end else begin
                    nxt_mode = mode_ff + 2'h1;
                end
            end else begin
                nxt_tmr = tmr_ff + 14'h1;
            end
        end else if (!search) begin
            nxt_done = 1'b0;
            nxt_tmr = 14'h0;
        end
        // Polarity follows sense only while the link is down and speed is not 100M
        if (!pol_en) begin
            nxt_pol = 4'h0;
        end else if (!link_up) begin
            if (speed == pls_pkg::PLS_SPD_100) begin
                nxt_pol = 4'h0;
            end else begin
                nxt_pol = pol_sense;
            end
        end
    end
    // Register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= 2'h0;
            pol_ff <= 4'h0;
            tmr_ff <= 14'h0;
            done_ff <= 1'b0;
        end else begin
            mode_ff <= nxt_mode;
            pol_ff <= nxt_pol;
            tmr_ff <= nxt_tmr;
            done_ff <= nxt_done;
        end
    end
    assign xover_mode = mode_ff;
    assign pol_inv = pol_ff;
    assign xover_done = done_ff;
endmodule

/* hw/pls_fallback.sv */
// Purpose: gigabit attempt counting and speed fallback decision
// Assumes: one-cycle event pulses
// Notes: attempt counter saturates
`timescale 1ns/10ps
`include "pls_consts.svh"
module pls_fallback (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Async reset, active low
    input wire logic enable, // Fallback allowed
    input wire logic g_fail, // Gigabit attempt failed
    input wire logic g_up, // Gigabit link came up
    input wire logic cable_bad, // Cabling unfit for gigabit
    input wire logic sig_bad, // Signal integrity unfit
    output logic fall_pulse // Fallback decision taken
);
    logic [2:0] cnt_ff, nxt_cnt;
    logic fall_ff, nxt_fall;
    // Next values for counter and decision
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_fall = 1'b0;
        if (g_up) begin
            nxt_cnt = 3'h0;
        end else if (g_fail && cnt_ff != 3'h7) begin
            nxt_cnt = cnt_ff + 3'h1;
        end
        if (enable && !g_up) begin
            if (cable_bad || sig_bad) begin
                nxt_fall = 1'b1;
            end else if (cnt_ff > 3'(`PLS_ATTEMPT_MAX)) begin
                nxt_fall = 1'b1;
            end
        end
        if (nxt_fall) begin
            nxt_cnt = 3'h0;
        end
    end
    // Register stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 3'h0;
            fall_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            fall_ff <= nxt_fall;
        end
    end
    assign fall_pulse = fall_ff;
endmodule

/* test/pls_top_asserts.sv */
// Purpose: port checker for the link start-up block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every pls_top instance
`timescale 1ns/10ps
module pls_top_asserts (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic [3:0] pol_inv_o, // Polarity inversion
    input wire logic capability_exchange_active, // Exchange running
    input wire logic [2:0] adv_o, // Advertised abilities
    input wire logic link_up_o, // Link established
    input wire logic [1:0] speed_o // Link speed
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Access phase still waiting for the slave
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // Ready stands exactly one cycle
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_answer_next: assert property (s_access |=> s_answer)
        else $error("pready late or held too long");
    a_ready_cause: assert property
        (pready |-> $past(psel) && $past(penable))
        else $error("pready without an access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside an answer");
    a_adv_reset: assert property ($rose(presetn) |-> adv_o == 3'h7)
        else $error("advertisement wrong after reset");
    a_pol_frozen: assert property
        (link_up_o && $past(link_up_o) |-> $stable(pol_inv_o))
        else $error("polarity moved while link up");
    a_link_no_exch: assert property (link_up_o |-> !capability_exchange_active)
        else $error("exchange running with link up");
    a_gig_adv: assert property
        (link_up_o && speed_o == 2'h2 |-> adv_o[2])
        else $error("gigabit link without gigabit advert");
    a_adv_drop_down: assert property ($fell(adv_o[2]) |-> !link_up_o)
        else $error("gigabit advert cleared with link up");
endmodule
bind pls_top pls_top_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .pol_inv_o, .capability_exchange_active, .adv_o, .link_up_o,
    .speed_o);

/* test/pls_partner.sv */
// Purpose: remote link partner seen across the cable
// Assumes: line status as levels synchronous to pclk
// Notes: mode 0 ok, 1 silent, 2 train fail, 3 bad cable, 4 noise
`timescale 1ns/10ps
module pls_partner (
    input wire logic pclk, // Core clock
    input wire logic presetn, // Reset, active low
    input wire logic capability_exchange_active, // Local exchange running
    input wire logic link_up, // Local link state
    input wire logic [2:0] mode, // Behaviour chosen by bench
    input wire logic [3:0] dly, // Answer delay in cycles
    input wire logic [3:0] pol, // Pair polarity presented
    input wire logic drop, // Break the link
    input wire logic pulse_off, // Withhold link pulses
    output logic lp_capability_exchange_ok, // Exchange done
    output logic lp_no_capability_exchange, // Partner silent
    output logic [1:0] pdet_speed, // Detected signalling
    output logic [2:0] lp_abil, // Partner abilities
    output logic lp_pulse_ok, // Link pulses valid
    output logic [3:0] pol_sense, // Polarity sense
    output logic train_ok, // Training done
    output logic train_fail, // Training failed
    output logic cable_bad, // Cable unfit
    output logic sig_bad, // Signal unfit
    output logic link_lost // Line dropped
);
    int acnt; // Cycles into exchange
    int tcnt; // Cycles since exchange or link up ended
    // Track the local side's phases
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acnt <= 0;
            tcnt <= 0;
        end else begin
            acnt <= capability_exchange_active ? acnt + 1 : 0;
            tcnt <= (capability_exchange_active || link_up) ? 0 : tcnt + 1;
        end
    end
    // Answers held as levels once the delay has run
    always_comb begin
        lp_capability_exchange_ok = capability_exchange_active && acnt > dly && mode != 3'h1;
        lp_no_capability_exchange = capability_exchange_active && acnt > dly && mode == 3'h1;
        pdet_speed = 2'h1;
        lp_abil = 3'h7;
        lp_pulse_ok = presetn && !pulse_off;
        pol_sense = pol;
        train_ok = tcnt > dly && mode == 3'h0;
        train_fail = tcnt > dly && mode == 3'h2;
        cable_bad = tcnt > dly && mode == 3'h3;
        sig_bad = tcnt > dly && mode == 3'h4;
        link_lost = drop;
    end
endmodule

/* test/pls_top_tb.sv */
// Purpose: self-checking bench for the link start-up block
// Assumes: partner model answers on the line side
// Notes: model keeps advertisement and fallback count
`timescale 1ns/10ps
module pls_top_tb;
    logic pclk = 0, presetn = 0; // Clock and reset
    logic psel = 0, penable = 0, pwrite = 0; // APB controls
    logic [11:0] paddr = 12'h0; // APB address
    logic [31:0] pwdata = 32'h0, prdata, rd_v; // APB data
    logic pready, pslverr, rd_e; // APB answer
    logic lp_capability_exchange_ok, lp_no_capability_exchange, lp_pulse_ok, train_ok, train_fail;
    logic cable_bad, sig_bad, link_lost; // Line status
    logic [1:0] pdet_speed, xover_mode_o, speed_o; // Speeds, mode
    logic [2:0] lp_abil, adv_o, mode = 3'h0; // Abilities, behaviour
    logic [3:0] pol_sense, pol_inv_o, dly = 4'h1, pol = 4'h0, p_hold;
    logic capability_exchange_active, xpage_active, link_up_o; // Line state
    logic drop = 0, saw_xp = 0; // Link break, page seen
    logic pulse_off = 0; // Partner pulses withheld
    int fails = 0, n_checks = 0, seed = 9941, m_adv = 7, m_err = 0;
    pls_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .lp_capability_exchange_ok, .lp_no_capability_exchange,
        .pdet_speed, .lp_abil, .lp_pulse_ok, .pol_sense, .train_ok,
        .train_fail, .cable_bad, .sig_bad, .link_lost, .xover_mode_o,
        .pol_inv_o, .capability_exchange_active, .xpage_active, .adv_o, .link_up_o,
        .speed_o);
    pls_partner u_lp (.pclk, .presetn, .capability_exchange_active, .link_up(link_up_o),
        .mode, .dly, .pol, .drop, .pulse_off, .lp_capability_exchange_ok, .lp_no_capability_exchange,
        .pdet_speed,
        .lp_abil, .lp_pulse_ok, .pol_sense, .train_ok, .train_fail,
        .cable_bad, .sig_bad, .link_lost);
    // Clock at 100 MHz
    always #5 pclk = ~pclk;
    // Remember that extra pages were exchanged
    always @(posedge pclk) if (xpage_active === 1'b1) saw_xp <= 1;
    // Compare one result with the model
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd_v = prdata;
        rd_e = pslverr;
        if (n >= 50) fails++;
        // Release only after the edge that samples pready high
        @(posedge pclk);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Read and compare a register
    task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(0, a, 32'h0);
        cmp(nm, e, rd_v);
    endtask
    // New advertisement, then restart the link
    task go(input int adv);
        dly <= $random(seed);
        m_adv = adv;
        apb(1, 12'h004, adv);
        apb(1, 12'h000, 32'h1f);
    endtask
    // Let a live link drop, then wait for the next one
    task wait_up;
        int n;
        n = 0;
        while (link_up_o === 1'b1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (link_up_o !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        cmp("link", 32'h1, link_up_o);
    endtask
    // Verdict and end of run
    task summarize;
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Cut a hang short
    initial begin
        #900000;
        fails++;
        summarize();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(12'h000, 32'hf, "ctrl");
        rd(12'h004, 32'h7, "adv");
        rd(12'h00c, 32'h0, "errcnt");
        apb(1, 12'h010, 32'hffff_ffff);
        cmp("wr_err", 32'h1, rd_e);
        rd(12'h010, 32'h0, "unmapped");
        cmp("rd_err", 32'h1, rd_e);
        // Gigabit link with random polarity, then frozen
        p_hold = $random(seed);
        pol <= p_hold;
        go(7);
        wait_up();
        cmp("speed", 32'h2, speed_o);
        cmp("pol", p_hold, pol_inv_o);
        cmp("xpage", 32'h1, saw_xp);
        pol <= ~p_hold;
        repeat (20) @(posedge pclk);
        cmp("pol_held", p_hold, pol_inv_o);
        apb(0, 12'h008, 32'h0);
        cmp("stat", {p_hold, 3'h5}, {rd_v[9:6], rd_v[3:1]});
        // Fallback by failed attempts, bad cable and noise
        for (int k = 2; k < 5; k++) begin
            mode <= k[2:0];
            if (k == 2) begin
                drop <= 1;
                @(posedge pclk);
                drop <= 0;
            end else begin
                go(7);
            end
            m_adv = 3;
            m_err++;
            wait_up();
            cmp("fb_speed", 32'h1, speed_o);
            cmp("fb_adv", m_adv, adv_o);
            rd(12'h00c, m_err, "errcnt");
        end
        // Silent partner gives parallel detection
        mode <= 3'h1;
        go(7);
        wait_up();
        cmp("pdet", 32'h1, speed_o);
        // Gigabit only: failures never fall back
        mode <= 3'h2;
        go(4);
        repeat (2000) @(posedge pclk);
        cmp("g_only_adv", m_adv, adv_o);
        cmp("g_only_link", 32'h0, link_up_o);
        rd(12'h00c, m_err, "errcnt");
        // Exchange disabled, restart clears itself
        apb(1, 12'h000, 32'h1e);
        repeat (200) @(posedge pclk);
        cmp("no_exch", 32'h0, capability_exchange_active);
        rd(12'h000, 32'he, "ctrl_rst");
        // No pulses at 100M: search toggles between two modes only
        pulse_off <= 1;
        apb(1, 12'h000, 32'h1e);
        repeat (1500) @(posedge pclk);
        cmp("xmode_step", 32'h1, xover_mode_o);
        repeat (1000) @(posedge pclk);
        cmp("xmode_pair", 32'h0, xover_mode_o);
        pulse_off <= 0;
        wait_up();
        cmp("xmode_lock", 32'h0, xover_mode_o);
        summarize();
    end
endmodule
